/* File: design/pie_pkg.sv */
// Package for the peripheral interrupt enable bank: offsets, bit positions, types.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package pie_pkg;
  localparam logic [3:0] PIE_ADR_ENABLE_TWO   = 4'h0;
  localparam logic [3:0] PIE_ADR_ENABLE_THREE = 4'h4;
  localparam logic [3:0] PIE_ADR_FLAG_TWO     = 4'h8;
  localparam logic [3:0] PIE_ADR_FLAG_THREE   = 4'hc;
  localparam logic [7:0] PIE_RST_ENABLE       = 8'h00;
  localparam logic [7:0] PIE_RST_FLAG         = 8'h00;
  // Implemented bit masks
  localparam logic [7:0] PIE_MASK_TWO         = 8'hf9;
  localparam logic [7:0] PIE_MASK_THREE       = 8'h3a;
  localparam int PIE_BIT_OSC_FAIL    = 7;
  localparam int PIE_BIT_COMP_TWO    = 6;
  localparam int PIE_BIT_COMP_ONE    = 5;
  localparam int PIE_BIT_EEPROM_DONE = 4;
  localparam int PIE_BIT_BUS_COLL    = 3;
  localparam int PIE_BIT_CAPCOMP_TWO = 0;
  localparam int PIE_BIT_CAPCOMP_FOUR  = 5;
  localparam int PIE_BIT_CAPCOMP_THREE = 4;
  localparam int PIE_BIT_TIMER_SIX     = 3;
  localparam int PIE_BIT_TIMER_FOUR    = 1;

  typedef struct packed {
    logic [7:0] bank_two;
    logic [7:0] bank_three;
  } pie_bank_s;
endpackage : pie_pkg

/* File: design/pie_enable_bank.sv */
// Peripheral interrupt enable banks two and three with their request flags.
// Assumes event pulses from peripherals on clk_i and a classic Wishbone master.
`timescale 1ns/1ps
module pie_enable_bank
  import pie_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire pie_bank_s   event_i,
  input  wire logic        peripheral_master_enable_i,
  input  wire logic        global_interrupt_enable_i,
  output logic             core_irq_o
);
  pie_bank_s   en_reg, en_next;
  pie_bank_s   flag_reg, flag_next;
  logic [31:0] dat_reg, dat_next;
  logic        ack_reg, ack_next;
  logic        irq_reg, irq_next;
  logic        req, wr;
  logic        wr_en_two, wr_en_three;
  logic        wr_flag_two, wr_flag_three;
  logic [7:0]  pend_two, pend_three;

  function automatic logic [7:0] pie_write(input logic [7:0] old, input logic [7:0] wdat,
                                           input logic [7:0] mask);
    pie_write = (old & ~mask) | (wdat & mask);
  endfunction : pie_write

  // Address decode shared by the write strobes
  function automatic logic pie_hit(input logic [3:0] adr, input logic [3:0] target);
    pie_hit = (adr == target);
  endfunction : pie_hit

  // Read mux masks again, so a stray unimplemented bit can never leak out
  function automatic logic [31:0] pie_read(input logic [3:0] adr, input pie_bank_s en,
                                           input pie_bank_s flag);
    case (adr)
      PIE_ADR_ENABLE_TWO:   pie_read = {24'h000000, en.bank_two & PIE_MASK_TWO};
      PIE_ADR_ENABLE_THREE: pie_read = {24'h000000, en.bank_three & PIE_MASK_THREE};
      PIE_ADR_FLAG_TWO:     pie_read = {24'h000000, flag.bank_two & PIE_MASK_TWO};
      PIE_ADR_FLAG_THREE:   pie_read = {24'h000000, flag.bank_three & PIE_MASK_THREE};
      default:              pie_read = 32'h00000000;
    endcase
  endfunction : pie_read

  // A standing ack blocks a second take of the same request
  assign req           = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr            = req && wb_we_i && wb_sel_i[0];
  assign wr_en_two     = wr && pie_hit(wb_adr_i, PIE_ADR_ENABLE_TWO);
  assign wr_en_three   = wr && pie_hit(wb_adr_i, PIE_ADR_ENABLE_THREE);
  assign wr_flag_two   = wr && pie_hit(wb_adr_i, PIE_ADR_FLAG_TWO);
  assign wr_flag_three = wr && pie_hit(wb_adr_i, PIE_ADR_FLAG_THREE);

  // Enable group
  always_comb begin
    en_next = en_reg;
    if (wr_en_two) begin
      en_next.bank_two = pie_write(en_reg.bank_two, wb_dat_i[7:0], PIE_MASK_TWO);
    end
    if (wr_en_three) begin
      en_next.bank_three = pie_write(en_reg.bank_three, wb_dat_i[7:0], PIE_MASK_THREE);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg <= '{bank_two: PIE_RST_ENABLE, bank_three: PIE_RST_ENABLE};
    end else if (ce_i) begin
      en_reg <= en_next;
    end
  end

  // Flag group; software clears by writing, a written one also sets as a test aid
  always_comb begin
    flag_next = flag_reg;
    if (wr_flag_two) begin
      flag_next.bank_two = pie_write(flag_reg.bank_two, wb_dat_i[7:0], PIE_MASK_TWO);
    end
    if (wr_flag_three) begin
      flag_next.bank_three = pie_write(flag_reg.bank_three, wb_dat_i[7:0], PIE_MASK_THREE);
    end
    // Events win over a clear in the same cycle
    flag_next.bank_two   = flag_next.bank_two | (event_i.bank_two & PIE_MASK_TWO);
    flag_next.bank_three = flag_next.bank_three | (event_i.bank_three & PIE_MASK_THREE);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= '{bank_two: PIE_RST_FLAG, bank_three: PIE_RST_FLAG};
    end else if (ce_i) begin
      flag_reg <= flag_next;
    end
  end

  // Bus response group; read data stands until the next access
  always_comb begin
    dat_next = dat_reg;
    ack_next = 1'b0;
    if (req) begin
      ack_next = 1'b1;
      dat_next = pie_read(wb_adr_i, en_reg, flag_reg);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dat_reg <= 32'h00000000;
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      dat_reg <= dat_next;
      ack_reg <= ack_next;
    end
  end

  // Request group; registered so a glitch on the gating inputs never reaches the core
  assign pend_two   = flag_reg.bank_two & en_reg.bank_two;
  assign pend_three = flag_reg.bank_three & en_reg.bank_three;

  always_comb begin
    irq_next = global_interrupt_enable_i && peripheral_master_enable_i &&
               ((|pend_two) || (|pend_three));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= irq_next;
    end
  end

  assign wb_dat_o   = dat_reg;
  assign wb_ack_o   = ack_reg;
  assign core_irq_o = irq_reg;

  // Register map and request checks
  a_master_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ce_i) && !$past(peripheral_master_enable_i) |-> !core_irq_o)
    else $error("irq without peripheral master enable");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ((en_reg.bank_two & ~PIE_MASK_TWO) == 8'h00) &&
    ((en_reg.bank_three & ~PIE_MASK_THREE) == 8'h00))
    else $error("unimplemented enable bit set");
  a_flag_unimpl: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_reg.bank_two & 8'h06) == 8'h00)
    else $error("flag bank two bits 2-1 set");
  a_event_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && event_i.bank_two[PIE_BIT_OSC_FAIL] |=> flag_reg.bank_two[PIE_BIT_OSC_FAIL])
    else $error("event lost");
  a_enable_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && en_reg == '0 |=> !core_irq_o)
    else $error("irq with no enable");
  a_irq_raised: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && global_interrupt_enable_i && peripheral_master_enable_i &&
    flag_reg.bank_three[PIE_BIT_TIMER_FOUR] && en_reg.bank_three[PIE_BIT_TIMER_FOUR]
    |=> core_irq_o)
    else $error("irq not raised");
  a_write_two: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr && wb_adr_i == PIE_ADR_ENABLE_TWO |=>
    en_reg.bank_two == ($past(wb_dat_i[7:0]) & PIE_MASK_TWO))
    else $error("bank two write wrong");
  a_write_three: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr && wb_adr_i == PIE_ADR_ENABLE_THREE |=>
    en_reg.bank_three == ($past(wb_dat_i[7:0]) & PIE_MASK_THREE))
    else $error("bank three write wrong");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // Gating, freeze and bus checks
  a_global_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ce_i) && !$past(global_interrupt_enable_i) |-> !core_irq_o)
    else $error("irq without global enable");

  a_irq_two_src: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && global_interrupt_enable_i && peripheral_master_enable_i &&
    flag_reg.bank_two[PIE_BIT_CAPCOMP_TWO] && en_reg.bank_two[PIE_BIT_CAPCOMP_TWO]
    |=> core_irq_o)
    else $error("enabled source did not raise irq");

  a_event_three: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && event_i.bank_three[PIE_BIT_TIMER_SIX] |=>
    flag_reg.bank_three[PIE_BIT_TIMER_SIX])
    else $error("timer six event lost");

  a_freeze_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> en_reg == $past(en_reg))
    else $error("enable bank moved while frozen");

  a_freeze_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> flag_reg == $past(flag_reg))
    else $error("flag bank moved while frozen");

  a_sel_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && wb_we_i && !wb_sel_i[0] |=> en_reg == $past(en_reg))
    else $error("write without low byte select landed");

  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req |=> wb_ack_o)
    else $error("request not answered");

  a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
endmodule : pie_enable_bank

/* File: testbench/pie_event_src.sv */
// Event source model: turns a request into an event pulse one clk_i cycle later, as long as fire_i is held.
// Assumes the bench drives fire_i just after a rising clk_i edge.
`timescale 1ns/1ps
module pie_event_src
  import pie_pkg::*;
(
  input  wire logic      clk_i,
  input  wire pie_bank_s fire_i,
  output pie_bank_s      event_o
);
  // Pulses whatever fire_i holds
  always_ff @(posedge clk_i) event_o <= fire_i;
endmodule : pie_event_src

/* File: testbench/pie_enable_bank_bench.sv */
// Bench for the enable banks: register map, flags and core request gating.
// Assumes pie_pkg and the event source model are compiled first.
`timescale 1ns/1ps
module pie_enable_bank_bench;
  import pie_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, pme, global_interrupt_enable, irq, ack;
  logic        ce;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat;
  logic [7:0]  q;
  pie_bank_s   fire, ev;
  int          err_count, tests_run, cycles;
  pie_event_src i_pie_event_src (.clk_i(clk_i), .fire_i(fire), .event_o(ev));
  pie_enable_bank i_pie_enable_bank (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .event_i(ev),
    .peripheral_master_enable_i(pme), .global_interrupt_enable_i(global_interrupt_enable),
    .core_irq_o(irq));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Entered just after a rising edge; ack read before that edge's updates land
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic t_reset();
    for (int a = 0; a < 16; a += 4) begin
      wb(1'b0, a[3:0], 8'h00); chk("reset value", q, 8'h00);
    end
  endtask : t_reset
  task automatic t_map();
    wb(1'b1, 4'h0, 8'hff); wb(1'b0, 4'h0, 8'h00); chk("bank two", q, 8'hf9);
    wb(1'b1, 4'h4, 8'hff); wb(1'b0, 4'h4, 8'h00); chk("bank three", q, 8'h3a);
    wb(1'b1, 4'h2, 8'hff); wb(1'b0, 4'h2, 8'h00); chk("unmapped", q, 8'h00);
  endtask : t_map
  task automatic t_gate();
    wb(1'b1, 4'h8, 8'h00); wb(1'b1, 4'hc, 8'h00);
    fire <= '{bank_two: 8'hff, bank_three: 8'hff};
    @(posedge clk_i); fire <= '0; repeat (3) @(posedge clk_i);
    chk("irq master off", {7'h0, irq}, 8'h00);
    wb(1'b0, 4'h8, 8'h00); chk("flag two", q, 8'hf9);
    pme <= 1'b1; global_interrupt_enable <= 1'b1; repeat (2) @(posedge clk_i);
    chk("irq on", {7'h0, irq}, 8'h01);
    wb(1'b1, 4'h0, 8'h00); wb(1'b1, 4'h4, 8'h00);
    chk("irq blocked", {7'h0, irq}, 8'h00);
    wb(1'b1, 4'h0, 8'h01); @(posedge clk_i);
    chk("irq one bit", {7'h0, irq}, 8'h01);
  endtask : t_gate
  task automatic t_sel();
    sel <= 4'he;
    wb(1'b1, 4'h0, 8'h00);
    sel <= 4'hf;
    wb(1'b0, 4'h0, 8'h00);
    chk("sel low byte off", q, 8'hf9);
  endtask : t_sel
  // Events during a freeze must be lost, so the flag stays clear
  task automatic t_freeze();
    wb(1'b1, 4'hc, 8'h00);
    ce <= 1'b0;
    fire <= '{bank_two: 8'h00, bank_three: 8'h3a};
    @(posedge clk_i);
    fire <= '0;
    repeat (2) @(posedge clk_i);
    ce <= 1'b1;
    @(posedge clk_i);
    wb(1'b0, 4'hc, 8'h00);
    chk("flag frozen", q, 8'h00);
  endtask : t_freeze
  task automatic t_gie();
    chk("irq before gate", {7'h0, irq}, 8'h01);
    global_interrupt_enable <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("irq global off", {7'h0, irq}, 8'h00);
  endtask : t_gie
  task automatic t_rerun();
    global_interrupt_enable <= 1'b1;
    rst_i <= 1'b1;
    @(posedge clk_i);
    chk("irq in reset", {7'h0, irq}, 8'h00);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 4'h0, 8'h00);
    chk("enable after reset", q, 8'h00);
    wb(1'b0, 4'h8, 8'h00);
    chk("flag after reset", q, 8'h00);
  endtask : t_rerun
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 2000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {rst_i, cyc, stb, we, pme, global_interrupt_enable, adr, wdat, fire} = '0;
    {err_count, tests_run, cycles} = '0;
    ce = 1'b1;
    sel = 4'hf;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_map();
    t_sel();
    t_gate();
    t_freeze();
    t_gie();
    t_rerun();
    conclude();
  end
endmodule : pie_enable_bank_bench
